//--- logic/mgmc_device.sv
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
// Contract
// - Event code: none, ready, motion, fault
// - Flag protocol faults on the link
// - Activity bits: low zero, high busy
// - Motion flag cleared by launch bit
// - Rate by register or broadcast command
// - Host programs nonzero rate first
// - Rate 255 plus high power: 1000 Hz
// - Host respects bandwidth rate ceilings
// - Magnetic trigger runs one, self-clears
// - Temperature trigger runs one, self-clears
// - Set trigger: coil pulse 375 ns; code rounds up to 4 cycles, 400 ns
// - Reset trigger: coil pulse 375 ns; code rounds up to 4 cycles, 400 ns
// - Auto flip wraps every magnetic measurement
// - Self-test runs then clears enable
// - Compute bit latches period, self-clears
// - Continuous needs rate, compute, run
// - Bandwidth selects measurement duration
// - Ready rises at end, clears on events
module mgmc_device
  import mgmc_pkg::*;
#(
  parameter int MEAS_CYC_BW0 = MEAS_BW0_NS / CLK_PERIOD_NS,
  parameter int MEAS_CYC_BW1 = MEAS_BW1_NS / CLK_PERIOD_NS,
  parameter int MEAS_CYC_BW2 = MEAS_BW2_NS / CLK_PERIOD_NS,
  parameter int MEAS_CYC_BW3 = MEAS_BW3_NS / CLK_PERIOD_NS,
  parameter int TEMP_CYC = TEMP_MEAS_NS / CLK_PERIOD_NS,
  parameter int TEST_CYC = SELFTEST_NS / CLK_PERIOD_NS,
  parameter int CLK_HZ = SYS_CLK_HZ
)(
  input wire logic hclk, // Device clock
  input wire logic hresetn, // Async reset
  mgmc_link_if.device link, // Serial link
  input wire logic [1:0] bandwidth_select, // Measurement bandwidth
  input wire logic high_power, // High-power select
  input wire logic continuous_run, // Continuous-run enable
  input wire logic motion_detect, // Motion detector event
  input wire logic mag_data_read, // Magnetic data accessed
  input wire logic temp_data_read, // Temperature data accessed
  input wire logic ibi_sent, // In-band interrupt sent
  input wire logic event_read, // Ready bits read
  output logic set_coil_on, // Set current flowing
  output logic reset_coil_on, // Reset current flowing
  output logic measure_busy, // Measurement active
  output logic magnetic_ready, // Magnetic data ready
  output logic temperature_ready, // Temperature data ready
  output logic motion_seen, // Motion flag
  output logic continuous_on, // Continuous mode active
  output logic auto_flip_enable // Auto set/reset enabled
);

  mgmc_dev_t r;
  mgmc_dev_t n;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic frame_on;
  logic is_ccc;
  logic busy;
  logic cont;
  logic [7:0] nb;
  logic [7:0] stat_byte;
  logic [1:0] ev_code;
  logic [23:0] meas_len;
  logic [23:0] acc_sum;

  ////////////////////////////////////////////////////////////////////////////////
  // Decodes
  assign sclk_rise = r.sclk_s[1] & ~r.sclk_d;
  assign sclk_fall = ~r.sclk_s[1] & r.sclk_d;
  assign cs_rise = r.cs_s[1] & ~r.cs_d;
  assign frame_on = ~r.cs_s[1];
  assign nb = {r.rx[6:0], r.mosi_s[1]};
  assign is_ccc = r.hdr[6:0] == CCC_BCAST;
  assign busy = r.state != D_IDLE;
  assign cont = continuous_run & (r.rate != RATE_RESET) & r.period_valid;
  assign acc_sum = r.acc + 24'(r.step);

  // Pending event code, fault highest
  assign ev_code = r.proto_fault ? EV_FAULT :
    r.motion_seen ? EV_MOTION :
    (r.mag_ready | r.temp_ready) ? EV_READY : EV_NONE;
  assign stat_byte = {busy, 1'b0, r.proto_fault, r.motion_seen, 2'b00, ev_code};

  // Duration per bandwidth
  always_comb
  begin
    unique case (bandwidth_select)
      2'b00: meas_len = 24'(MEAS_CYC_BW0 - 1);
      2'b01: meas_len = 24'(MEAS_CYC_BW1 - 1);
      2'b10: meas_len = 24'(MEAS_CYC_BW2 - 1);
      2'b11: meas_len = 24'(MEAS_CYC_BW3 - 1);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    n = r;
    n.sclk_s = {r.sclk_s[0], link.sclk};
    n.cs_s = {r.cs_s[0], link.cs_n};
    n.mosi_s = {r.mosi_s[0], link.mosi};
    n.sclk_d = r.sclk_s[1];
    n.cs_d = r.cs_s[1];
    n.cmd[CMD_MOTION] = 1'b0;

    // Ready clears first so that a completion wins
    if (mag_data_read | ibi_sent | event_read)
    begin
      n.mag_ready = 1'b0;
    end
    if (temp_data_read | ibi_sent | event_read)
    begin
      n.temp_ready = 1'b0;
    end

    // Link receive
    if (!frame_on)
    begin
      n.bit_cnt = '0;
      n.miso = 1'b0;
    end
    if (frame_on && sclk_rise)
    begin
      n.rx = nb;
      if (r.bit_cnt != CNT_MAX)
      begin
        n.bit_cnt = r.bit_cnt + 5'd1;
      end
      if (r.bit_cnt == HDR_LAST)
      begin
        n.hdr = nb;
        n.tx = 8'h00;
        if (nb[7] && nb[6:0] == REG_STATUS)
        begin
          n.tx = stat_byte;
          n.proto_fault = 1'b0;
        end
      end
      if (r.bit_cnt == DATA_LAST && !r.hdr[7])
      begin
        if (is_ccc)
        begin
          n.ccc_def = nb;
        end
        else if (r.hdr[6:0] == REG_RATE)
        begin
          n.rate = nb;
        end
        else if (r.hdr[6:0] == REG_CMD)
        begin
          n.cmd = r.cmd | nb;
          n.cmd[CMD_FLIP] = nb[CMD_FLIP];
          if (nb[CMD_MOTION])
          begin
            n.motion_seen = 1'b0;
          end
          if (nb[CMD_MAG])
          begin
            n.mag_ready = 1'b0;
          end
          if (nb[CMD_TEMP])
          begin
            n.temp_ready = 1'b0;
          end
        end
      end
      if (r.bit_cnt == CCC_LAST && !r.hdr[7] && is_ccc && r.ccc_def == CCC_DEF_RATE)
      begin
        n.rate = nb;
      end
    end

    // Read data shifts out on falling edges
    if (frame_on && sclk_fall && r.bit_cnt >= FRAME_BITS - 5'd8 && r.hdr[7])
    begin
      n.miso = r.tx[7];
      n.tx = {r.tx[6:0], 1'b0};
    end

    // Frame length or command check at frame end
    if (cs_rise)
    begin
      if (!((r.bit_cnt == FRAME_BITS && !is_ccc) ||
            (r.bit_cnt == CCC_FRAME_BITS && is_ccc && !r.hdr[7] &&
             r.ccc_def == CCC_DEF_RATE)))
      begin
        n.proto_fault = 1'b1;
      end
    end

    // Period compute
    if (r.cmd[CMD_CALC])
    begin
      n.step = (high_power && r.rate == RATE_MAX) ? 10'(FAST_RATE_HZ) : {2'b00, r.rate};
      n.period_valid = 1'b1;
      n.cmd[CMD_CALC] = 1'b0;
    end

    // Measurement sequencer
    if (r.timer != 24'd0)
    begin
      n.timer = r.timer - 24'd1;
    end
    unique case (r.state)
      D_IDLE:
      begin
        if (r.cmd[CMD_SET])
        begin
          n.state = D_SET;
          n.timer = COIL_PULSE_CYC - 24'd1;
        end
        else if (r.cmd[CMD_RST])
        begin
          n.state = D_RST;
          n.timer = COIL_PULSE_CYC - 24'd1;
        end
        else if (r.cmd[CMD_MAG] || r.tick)
        begin
          n.tick = 1'b0;
          if (r.cmd[CMD_FLIP])
          begin
            n.state = D_SET;
            n.auto_seq = 1'b1;
            n.timer = COIL_PULSE_CYC - 24'd1;
          end
          else
          begin
            n.state = D_MAG;
            n.timer = meas_len;
          end
        end
        else if (r.cmd[CMD_TEMP])
        begin
          n.state = D_TEMP;
          n.timer = 24'(TEMP_CYC - 1);
        end
        else if (r.cmd[CMD_TEST])
        begin
          n.state = D_TEST;
          n.timer = 24'(TEST_CYC - 1);
        end
      end
      D_SET:
      begin
        if (r.timer == 24'd0)
        begin
          if (r.auto_seq)
          begin
            n.state = D_RST;
            n.timer = COIL_PULSE_CYC - 24'd1;
          end
          else
          begin
            n.state = D_IDLE;
            n.cmd[CMD_SET] = 1'b0;
          end
        end
      end
      D_RST:
      begin
        if (r.timer == 24'd0)
        begin
          if (r.auto_seq)
          begin
            n.state = D_MAG;
            n.auto_seq = 1'b0;
            n.timer = meas_len;
          end
          else
          begin
            n.state = D_IDLE;
            n.cmd[CMD_RST] = 1'b0;
          end
        end
      end
      D_MAG:
      begin
        if (r.timer == 24'd0)
        begin
          n.state = D_IDLE;
          n.cmd[CMD_MAG] = 1'b0;
          n.mag_ready = 1'b1;
        end
      end
      D_TEMP:
      begin
        if (r.timer == 24'd0)
        begin
          n.state = D_IDLE;
          n.cmd[CMD_TEMP] = 1'b0;
          n.temp_ready = 1'b1;
        end
      end
      D_TEST:
      begin
        if (r.timer == 24'd0)
        begin
          n.state = D_IDLE;
          n.cmd[CMD_TEST] = 1'b0;
        end
      end
      default:
      begin
        n.state = D_IDLE;
      end
    endcase

    // Rate accumulator issues continuous ticks
    if (!cont)
    begin
      n.acc = '0;
    end
    else if (acc_sum >= 24'(CLK_HZ))
    begin
      n.acc = acc_sum - 24'(CLK_HZ);
      n.tick = 1'b1;
    end
    else
    begin
      n.acc = acc_sum;
    end

    // Motion set wins over launch clear
    if (motion_detect)
    begin
      n.motion_seen = 1'b1;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= DEV_INIT;
    end
    else
    begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.miso = r.miso;
  assign set_coil_on = r.state == D_SET;
  assign reset_coil_on = r.state == D_RST;
  assign measure_busy = busy;
  assign magnetic_ready = r.mag_ready;
  assign temperature_ready = r.temp_ready;
  assign motion_seen = r.motion_seen;
  assign continuous_on = cont;
  assign auto_flip_enable = r.cmd[CMD_FLIP];

endmodule

//--- logic/mgmc_host.sv
`timescale 1ns/1ps
module mgmc_host
  import mgmc_pkg::*;
(
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Async reset
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Response
  output logic [31:0] hrdata, // Read data
  output logic irq, // Interrupt level
  mgmc_link_if.host link // Serial link
);

  mgmc_host_t r;
  mgmc_host_t n;
  logic busy;
  logic [31:0] rd_val;

  assign busy = r.state != H_IDLE;

  ////////////////////////////////////////////////////////////////////////////////
  // Register read mux
  always_comb
  begin
    unique case (haddr[7:0])
      HOST_CMD: rd_val = {7'h00, r.cmd};
      HOST_STAT: rd_val = {16'h0000, r.rx, 7'h00, busy};
      HOST_IRQ: rd_val = {30'h0000_0000, r.irq_st};
      HOST_MASK: rd_val = {30'h0000_0000, r.mask};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    n = r;
    n.miso_s = {r.miso_s[0], link.miso};
    n.dp_valid = hsel & htrans[1] & hready;
    n.dp_write = hwrite;
    n.dp_addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      n.hrdata = rd_val;
    end

    // Data-phase writes
    if (r.dp_valid && r.dp_write)
    begin
      unique case (r.dp_addr)
        HOST_CMD:
        begin
          if (busy)
          begin
            n.irq_st[IRQ_REFUSED] = 1'b1;
          end
          else
          begin
            n.cmd = hwdata[24:0];
            n.sh = {hwdata[7:0], hwdata[15:8], hwdata[23:16]};
            n.bits_left = hwdata[24] ? CCC_FRAME_BITS : FRAME_BITS;
            n.cs_n = 1'b0;
            n.sclk = 1'b0;
            n.mosi = hwdata[7];
            n.div = LINK_HALF_CYC - 4'd1;
            n.state = H_LEAD;
          end
        end
        HOST_IRQ: n.irq_st = r.irq_st & ~hwdata[1:0];
        HOST_MASK: n.mask = hwdata[1:0];
        default: n.mask = r.mask;
      endcase
    end

    // Link sequencer, half period per phase
    if (r.div != 4'd0)
    begin
      n.div = r.div - 4'd1;
    end
    else
    begin
      unique case (r.state)
        H_IDLE: n.div = n.div; // Keep the lead-in count that a command write has just loaded
        H_LEAD:
        begin
          n.sclk = 1'b1;
          n.div = LINK_HALF_CYC - 4'd1;
          n.state = H_BITS;
        end
        H_BITS:
        begin
          n.div = LINK_HALF_CYC - 4'd1;
          if (r.sclk)
          begin
            n.rx = {r.rx[6:0], r.miso_s[1]};
            n.sclk = 1'b0;
            n.bits_left = r.bits_left - 5'd1;
            if (r.bits_left == 5'd1)
            begin
              n.state = H_TAIL;
            end
            else
            begin
              n.sh = {r.sh[22:0], 1'b0};
              n.mosi = r.sh[22];
            end
          end
          else
          begin
            n.sclk = 1'b1;
          end
        end
        H_TAIL:
        begin
          if (!r.cs_n)
          begin
            n.cs_n = 1'b1;
            n.mosi = 1'b0;
            n.div = LINK_HALF_CYC - 4'd1;
          end
          else
          begin
            n.state = H_IDLE;
            n.irq_st[IRQ_DONE] = 1'b1;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= HOST_INIT;
    end
    else
    begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.hrdata;
  assign irq = |(r.irq_st & r.mask);
  assign link.sclk = r.sclk;
  assign link.cs_n = r.cs_n;
  assign link.mosi = r.mosi;

endmodule

//--- logic/mgmc_link_if.sv
`timescale 1ns/1ps
// Serial link between controller and sensor
interface mgmc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport device (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

//--- logic/mgmc_pkg.sv
package mgmc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Device register map and frame layout
  localparam logic [6:0] REG_STATUS = 7'h19;
  localparam logic [6:0] REG_RATE = 7'h1A;
  localparam logic [6:0] REG_CMD = 7'h1B;
  localparam logic [6:0] CCC_BCAST = 7'h7E;
  localparam logic [7:0] CCC_DEF_RATE = 8'h8F;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] RATE_MAX = 8'hFF;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CCC_FRAME_BITS = 5'h18;
  localparam logic [4:0] HDR_LAST = 5'h07;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic [4:0] CCC_LAST = 5'h17;
  localparam logic [4:0] CNT_MAX = 5'h1F;

  // Command register bit positions
  localparam int CMD_MAG = 0;
  localparam int CMD_TEMP = 1;
  localparam int CMD_MOTION = 2;
  localparam int CMD_SET = 3;
  localparam int CMD_RST = 4;
  localparam int CMD_FLIP = 5;
  localparam int CMD_TEST = 6;
  localparam int CMD_CALC = 7;

  // Pending event codes
  localparam logic [1:0] EV_NONE = 2'h0;
  localparam logic [1:0] EV_READY = 2'h1;
  localparam logic [1:0] EV_MOTION = 2'h2;
  localparam logic [1:0] EV_FAULT = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int FAST_RATE_HZ = 1000;
  localparam int COIL_PULSE_NS = 375;
  localparam logic [23:0] COIL_PULSE_CYC =
    24'((COIL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int MEAS_BW0_NS = 6_600_000;
  localparam int MEAS_BW1_NS = 3_500_000;
  localparam int MEAS_BW2_NS = 2_000_000;
  localparam int MEAS_BW3_NS = 1_200_000;
  localparam int TEMP_MEAS_NS = 1_200_000;
  localparam int SELFTEST_NS = 6_600_000;
  localparam logic [3:0] LINK_HALF_CYC = 4'h4;

  ////////////////////////////////////////////////////////////////////////////////
  // Controller register map
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STAT = 8'h04;
  localparam logic [7:0] HOST_IRQ = 8'h08;
  localparam logic [7:0] HOST_MASK = 8'h0C;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // State types
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_SET = 3'b001,
    D_RST = 3'b010,
    D_MAG = 3'b011,
    D_TEMP = 3'b100,
    D_TEST = 3'b101
  } mgmc_dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LEAD = 2'b01,
    H_BITS = 2'b10,
    H_TAIL = 2'b11
  } mgmc_host_state_t;

  typedef struct packed {
    mgmc_dev_state_t state;
    logic [23:0] timer;
    logic [23:0] acc;
    logic [9:0] step;
    logic tick;
    logic auto_seq;
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic sclk_d;
    logic cs_d;
    logic [4:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] hdr;
    logic [7:0] ccc_def;
    logic [7:0] tx;
    logic miso;
    logic [7:0] rate;
    logic [7:0] cmd;
    logic period_valid;
    logic motion_seen;
    logic proto_fault;
    logic mag_ready;
    logic temp_ready;
  } mgmc_dev_t;

  typedef struct packed {
    mgmc_host_state_t state;
    logic [3:0] div;
    logic [4:0] bits_left;
    logic [23:0] sh;
    logic [7:0] rx;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic [1:0] miso_s;
    logic [24:0] cmd;
    logic [1:0] irq_st;
    logic [1:0] mask;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
  } mgmc_host_t;

  localparam mgmc_dev_t DEV_INIT = '{state: D_IDLE, cs_s: 2'b11, cs_d: 1'b1, default: '0};
  localparam mgmc_host_t HOST_INIT = '{state: H_IDLE, cs_n: 1'b1, default: '0};

endpackage

//--- verification/mgmc_assertions.sv
`timescale 1ns/1ps
module mgmc_assertions (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic sclk, // Link clock
  input wire logic cs_n, // Frame select
  input wire logic mosi, // Host data
  input wire logic miso, // Device data
  input wire logic set_coil_on, // Set current
  input wire logic reset_coil_on, // Reset current
  input wire logic measure_busy, // Sequencer busy
  input wire logic magnetic_ready // Magnetic data ready
);
  // Shared clock and reset for every property
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Link framing
  property p_sclk_idle; cs_n |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("Link clock moves outside a frame");
  property p_sclk_half; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("Link clock high phase not four cycles");
  property p_cs_lead; $fell(cs_n) |-> !sclk [*4]; endproperty
  a_cs_lead: assert property (p_cs_lead)
    else $error("Link clock rises too soon after select");
  property p_mosi_hold; sclk |-> $stable(mosi); endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("Host data changes while link clock high");
  property p_miso_idle; cs_n [*6] |-> !miso; endproperty
  a_miso_idle: assert property (p_miso_idle)
    else $error("Device data not low outside a frame");
  // Coil pulses and activity
  property p_set_len; $rose(set_coil_on) |-> set_coil_on [*4] ##1 !set_coil_on; endproperty
  a_set_len: assert property (p_set_len)
    else $error("Set pulse length wrong");
  property p_rst_len; $rose(reset_coil_on) |-> reset_coil_on [*4] ##1 !reset_coil_on; endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("Reset pulse length wrong");
  property p_coil_excl; !(set_coil_on && reset_coil_on); endproperty
  a_coil_excl: assert property (p_coil_excl)
    else $error("Set and reset currents together");
  property p_coil_busy; (set_coil_on || reset_coil_on) |-> measure_busy; endproperty
  a_coil_busy: assert property (p_coil_busy)
    else $error("Coil current while not busy");
  property p_ready_end; $rose(magnetic_ready) |-> $past(measure_busy); endproperty
  a_ready_end: assert property (p_ready_end)
    else $error("Ready rose without a measurement");
endmodule

//--- verification/mgmc_test.sv
`timescale 1ns/1ps
module mgmc_test;
  import mgmc_pkg::*;
  localparam int BW_CYC[4] = '{400, 300, 200, 160};
  localparam int T_CYC = 30;
  localparam int S_CYC = 50;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, high_power = 1'h0;
  logic continuous_run = 1'h0, motion_detect = 1'h0, event_read = 1'h0, ibi_sent = 1'h0;
  logic mag_data_read = 1'h0, temp_data_read = 1'h0;
  logic [1:0] htrans = 2'h0, bandwidth_select = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic hreadyout, hresp, irq, set_coil_on, reset_coil_on, measure_busy, magnetic_ready;
  logic temperature_ready, motion_seen, continuous_on, auto_flip_enable;
  int err_total = 0, n_compared = 0, run_len = 0, last_len = 0, cnt;
  mgmc_link_if link ();
  mgmc_host i_mgmc_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .link(link));
  mgmc_device #(.MEAS_CYC_BW0(BW_CYC[0]), .MEAS_CYC_BW1(BW_CYC[1]), .MEAS_CYC_BW2(BW_CYC[2]),
    .MEAS_CYC_BW3(BW_CYC[3]), .TEMP_CYC(T_CYC), .TEST_CYC(S_CYC), .CLK_HZ(100_000))
    i_mgmc_device (.hclk(hclk), .hresetn(hresetn), .link(link),
    .bandwidth_select(bandwidth_select), .high_power(high_power),
    .continuous_run(continuous_run), .motion_detect(motion_detect),
    .mag_data_read(mag_data_read), .temp_data_read(temp_data_read), .ibi_sent(ibi_sent),
    .event_read(event_read), .set_coil_on(set_coil_on), .reset_coil_on(reset_coil_on),
    .measure_busy(measure_busy), .magnetic_ready(magnetic_ready),
    .temperature_ready(temperature_ready), .motion_seen(motion_seen),
    .continuous_on(continuous_on), .auto_flip_enable(auto_flip_enable));
  mgmc_assertions i_mgmc_assertions (.hclk(hclk), .hresetn(hresetn), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .set_coil_on(set_coil_on),
    .reset_coil_on(reset_coil_on), .measure_busy(measure_busy),
    .magnetic_ready(magnetic_ready));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock generation
  initial
  begin
    forever #50 hclk = ~hclk;
  end
  // Length of the most recent busy period
  always @(posedge hclk)
  begin
    run_len <= (measure_busy === 1'h1) ? run_len + 1 : 0;
    if (measure_busy !== 1'h1 && run_len != 0)
      last_len <= run_len;
  end
  // Comparison, verdict and timeout
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo();
    err_total++;
    final_report();
  endtask
  // Bus cycles: address phase, then data phase
  task automatic wait_hr();
    int k;
    @(posedge hclk);
    for (k = 0; hreadyout !== 1'h1 && k < 50; k++) @(posedge hclk);
    if (k >= 50) tmo();
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_hr();
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    wait_hr();
    rd = hrdata;
  endtask
  // Link frames through the controller, waiting until it is idle again
  task automatic xfer(input logic [31:0] c);
    int k;
    ahb(1'h1, HOST_CMD, c);
    for (k = 0; k == 0 || (rd[0] !== 1'h0 && k < 300); k++) ahb(1'h0, HOST_STAT, 32'h0000_0000);
    if (k >= 300) tmo();
  endtask
  task automatic dwr(input logic [6:0] a, input logic [7:0] d);
    xfer({16'h0000, d, 1'h0, a});
  endtask
  task automatic drd(input logic [6:0] a);
    xfer({24'h00_0000, 1'h1, a});
  endtask
  task automatic bcast(input logic [7:0] df, input logic [7:0] r);
    xfer({7'h00, 1'h1, r, df, 1'h0, CCC_BCAST});
  endtask
  // Device side helpers
  task automatic wait_busy(input logic v);
    int k;
    for (k = 0; measure_busy !== v && k < 3000; k++) @(posedge hclk);
    if (k >= 3000) tmo();
  endtask
  task automatic meas(input logic [7:0] c, input int e);
    dwr(REG_CMD, c);
    wait_busy(1'h0);
    @(posedge hclk);
    chk(32'(last_len >= e - 1 && last_len <= e + 2), 32'h0000_0001, "busy length");
  endtask
  task automatic pulse(input int w);
    @(posedge hclk);
    {temp_data_read, mag_data_read, ibi_sent, event_read, motion_detect} <= 5'h01 << w;
    @(posedge hclk);
    {temp_data_read, mag_data_read, ibi_sent, event_read, motion_detect} <= 5'h00;
    repeat (3) @(posedge hclk);
  endtask
  task automatic idle_chk(input logic hi);
    cnt = 0;
    repeat (1200)
    begin
      @(posedge hclk);
      cnt += int'(measure_busy === 1'h0);
    end
    chk(32'(hi ? cnt > 400 : cnt < 100), 32'h0000_0001, "idle cycles");
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    drd(REG_STATUS);
    chk(rd[15:8], 8'h00, "status reset");
    drd(REG_RATE);
    chk(rd[15:8], 8'h00, "rate readback");
    ahb(1'h0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped");
    chk(hresp, 1'h0, "response");
    ahb(1'h1, HOST_MASK, 32'h0000_0003);
    dwr(REG_CMD, 8'h01);
    repeat (2) @(posedge hclk);
    chk(irq, 1'h1, "irq done");
    ahb(1'h1, HOST_CMD, {24'h00_0000, 1'h1, REG_STATUS});
    drd(REG_STATUS);
    chk(rd[15:8], 8'h80, "status busy");
    ahb(1'h0, HOST_IRQ, 32'h0000_0000);
    chk(rd, 32'h0000_0003, "irq status");
    ahb(1'h1, HOST_IRQ, 32'h0000_0003);
    repeat (2) @(posedge hclk);
    chk(irq, 1'h0, "irq clear");
    wait_busy(1'h0);
    drd(REG_STATUS);
    chk(rd[15:8], 8'h01, "status ready");
    pulse(3);
    chk(magnetic_ready, 1'h0, "mag read clear");
    meas(8'h08, int'(COIL_PULSE_CYC));
    meas(8'h10, int'(COIL_PULSE_CYC));
    meas(8'h02, T_CYC);
    chk(temperature_ready, 1'h1, "temp ready");
    pulse(2);
    chk(temperature_ready, 1'h0, "ibi clear");
    meas(8'h40, S_CYC);
    for (int b = 0; b < 8; b++)
    begin
      bandwidth_select <= b[1:0];
      meas(b > 3 ? 8'h21 : 8'h01, BW_CYC[b % 4] + (b > 3 ? 2 * int'(COIL_PULSE_CYC) : 0));
    end
    chk(auto_flip_enable, 1'h1, "auto flip");
    pulse(1);
    chk({magnetic_ready, temperature_ready}, 2'h0, "ready flags");
    meas(8'h02, T_CYC);
    pulse(4);
    chk(temperature_ready, 1'h0, "temp read clear");
    pulse(0);
    chk(motion_seen, 1'h1, "motion");
    drd(REG_STATUS);
    chk(rd[15:8], 8'h12, "status motion");
    dwr(REG_CMD, 8'h04);
    chk(motion_seen, 1'h0, "motion clear");
    bcast(8'h11, 8'h05);
    drd(REG_STATUS);
    chk(rd[15:8], 8'h23, "status fault");
    drd(REG_STATUS);
    chk(rd[15:8], 8'h00, "status idle");
    dwr(REG_RATE, 8'h64);
    continuous_run <= 1'h1;
    repeat (2) @(posedge hclk);
    chk(continuous_on, 1'h0, "no period");
    dwr(REG_CMD, 8'h80);
    chk(continuous_on, 1'h1, "continuous");
    wait_busy(1'h1);
    bcast(CCC_DEF_RATE, 8'h00);
    chk(continuous_on, 1'h0, "rate zero");
    bcast(CCC_DEF_RATE, RATE_MAX);
    dwr(REG_CMD, 8'h80);
    idle_chk(1'h1);
    high_power <= 1'h1;
    dwr(REG_CMD, 8'h80);
    idle_chk(1'h0);
    final_report();
  end
endmodule
